// ---- pmc_device.sv ----
// Receiver end: operating modes, dual clock output and wake-up timer
`timescale 1ns/1ns
`default_nettype none
module pmc_device
  import pmc_pkg::*;
#(
  parameter int unsigned XTAL_START_CYC = PMC_XTAL_START_CYC,
  parameter int unsigned RECAL_SLOW_CYC = PMC_RECAL_SLOW
) (
  input  wire logic       SYS_CLK_IN,
  input  wire logic       SYS_RST_IN,
  pmc_if.device           link,
  input  wire logic [6:0] AFC_OFFSET_IN,
  output logic [1:0]      MODE_OUT,
  output logic            XTAL_READY_OUT,
  output logic            CALIBRATING_OUT
);
  // ----------------------------------------------------------------
  // Operating mode
  // ----------------------------------------------------------------
  wire   en_bit   = link.rx_on;
  wire   ex_bit   = link.crystal_oscillator_on;
  wire   et_bit   = link.wakeup_timer_on;
  wire   keep_bit = link.wakeup_timer_on | link.battery_detector_on;
  pmc_mode_t nxt_mode;
  assign nxt_mode = (ex_bit & en_bit)  ? PMC_ACTIVE :
                    ex_bit             ? PMC_IDLE :
                    keep_bit           ? PMC_SLEEP : PMC_STANDBY;
  pmc_mode_t mode_ff;

  // ----------------------------------------------------------------
  // Crystal oscillator and startup detection
  // ----------------------------------------------------------------
  // Receiver bit alone also runs the crystal so it can bring back fast;
  // a pending switch to slow keeps it until the fast phase has ended
  logic en_fast_ff;
  wire  xtal_req = ex_bit | en_bit;
  wire  slow_ok  = link.slow_clk_sel & et_bit;
  wire  xtal_run = xtal_req | (en_fast_ff & slow_ok);
  logic [PMC_CNT_W-1:0] xtal_cnt_ff;
  logic                 xtal_ready_ff;
  wire  xtal_done = (32'(xtal_cnt_ff) >= XTAL_START_CYC - 1);

  // ----------------------------------------------------------------
  // Fast and slow source clocks
  // ----------------------------------------------------------------
  logic [15:0] fcnt_ff;
  logic        fclk_ff;
  wire  [15:0] fast_half = pmc_fast_half(link.clk_div);
  wire         fast_wrap = (fcnt_ff >= fast_half - 16'h1);
  wire         fast_fall = xtal_ready_ff & fast_wrap & fclk_ff;

  // RC oscillator belongs to the wake-up timer
  wire         rc_run = et_bit;
  logic [15:0] scnt_ff;
  logic        sclk_ff;
  wire         slow_wrap = (scnt_ff == 16'(PMC_SLOW_HALF - 1));
  wire         slow_fall = rc_run & slow_wrap & sclk_ff;

  // ----------------------------------------------------------------
  // Glitch-free switch
  // ----------------------------------------------------------------
  // Each enable only rises on its own clock's falling edge and only
  // once the other enable has dropped, so no phase is cut short.
  wire  want_fast = xtal_ready_ff & xtal_req;
  wire  want_slow = ~want_fast & slow_ok;
  logic en_slow_ff;
  logic clk_out_ff;
  wire  nxt_clk_out = ~link.clock_output_off &
                      ((fclk_ff & en_fast_ff) |
                       (sclk_ff & en_slow_ff));

  // ----------------------------------------------------------------
  // Wake-up timer and calibration
  // ----------------------------------------------------------------
  logic        et_d_ff;
  logic [15:0] wk_cnt_ff;
  logic        wk_evt_ff;
  logic [4:0]  cal_cnt_ff;
  logic        cal_busy_ff;
  logic        cal_done_ff;
  logic [PMC_CNT_W-1:0] recal_cnt_ff;
  wire  auto_cal   = ~link.cal_off;
  wire  et_rise    = et_bit & ~et_d_ff;
  wire  long_per   = (link.wakeup_period >= PMC_LONG_PERIOD);
  wire  recal_hit  = long_per & auto_cal & slow_fall &
                     (32'(recal_cnt_ff) >= RECAL_SLOW_CYC - 1);
  wire  cal_start  = (et_rise & auto_cal) | recal_hit;
  wire  cal_end    = cal_busy_ff & slow_fall & (cal_cnt_ff == 5'h0);
  wire  wk_hit     = et_bit & ~cal_busy_ff & slow_fall &
                     (wk_cnt_ff >= link.wakeup_period - 16'h1);
  logic [6:0] offs_ff;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      mode_ff       <= PMC_SLEEP;
      xtal_cnt_ff   <= '0;
      xtal_ready_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      if (!xtal_run) begin
        xtal_cnt_ff   <= '0;
        xtal_ready_ff <= 1'b0;
      end else if (xtal_done) begin
        xtal_ready_ff <= 1'b1;
      end else begin
        xtal_cnt_ff <= xtal_cnt_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN || !xtal_ready_ff) begin
      fcnt_ff <= '0;
      fclk_ff <= 1'b0;
    end else if (fast_wrap) begin
      fcnt_ff <= '0;
      fclk_ff <= ~fclk_ff;
    end else begin
      fcnt_ff <= fcnt_ff + 16'h1;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN || !rc_run) begin
      scnt_ff <= '0;
      sclk_ff <= 1'b0;
    end else if (slow_wrap) begin
      scnt_ff <= '0;
      sclk_ff <= ~sclk_ff;
    end else begin
      scnt_ff <= scnt_ff + 16'h1;
    end
  end

  // Only a stop with no switch pending drops an enable at once
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      en_fast_ff <= 1'b0;
      en_slow_ff <= 1'b0;
      clk_out_ff <= 1'b0;
    end else begin
      if (!xtal_ready_ff) begin
        en_fast_ff <= 1'b0;
      end else if (fast_fall) begin
        en_fast_ff <= want_fast & ~en_slow_ff;
      end
      if (!rc_run) begin
        en_slow_ff <= 1'b0;
      end else if (slow_fall) begin
        en_slow_ff <= want_slow & ~en_fast_ff;
      end
      clk_out_ff <= nxt_clk_out;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      et_d_ff      <= 1'b0;
      wk_cnt_ff    <= '0;
      wk_evt_ff    <= 1'b0;
      cal_cnt_ff   <= '0;
      cal_busy_ff  <= 1'b0;
      cal_done_ff  <= 1'b0;
      recal_cnt_ff <= '0;
    end else begin
      et_d_ff   <= et_bit;
      wk_evt_ff <= wk_hit;
      if (!et_bit) begin
        wk_cnt_ff   <= '0;
        cal_busy_ff <= 1'b0;
      end else if (cal_start) begin
        cal_busy_ff <= 1'b1;
        cal_cnt_ff  <= 5'(PMC_CAL_SLOW_CYC - 1);
        wk_cnt_ff   <= '0;
      end else if (cal_end) begin
        cal_busy_ff <= 1'b0;
        cal_done_ff <= 1'b1;
      end else if (cal_busy_ff && slow_fall) begin
        cal_cnt_ff <= cal_cnt_ff - 5'h1;
      end else if (wk_hit) begin
        wk_cnt_ff <= '0;
      end else if (slow_fall && !cal_busy_ff) begin
        wk_cnt_ff <= wk_cnt_ff + 16'h1;
      end
      if (!et_bit || !long_per || !auto_cal || cal_start) begin
        recal_cnt_ff <= '0;
      end else if (slow_fall) begin
        recal_cnt_ff <= recal_cnt_ff + 1'b1;
      end
    end
  end

  // Offset is only trusted while the host has AFC off
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      offs_ff <= '0;
    end else if (!link.afc_on) begin
      offs_ff <= AFC_OFFSET_IN;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.mcu_clk     = clk_out_ff;
  assign link.wakeup_evt  = wk_evt_ff;
  assign link.cal_done    = cal_done_ff;
  assign link.freq_offset = offs_ff;
  assign MODE_OUT         = mode_ff;
  assign XTAL_READY_OUT   = xtal_ready_ff;
  assign CALIBRATING_OUT  = cal_busy_ff;
endmodule
`default_nettype wire

// ---- pmc_pkg.sv ----
// Shared constants and types for the power mode and clock output control
package pmc_pkg;
  // ----------------------------------------------------------------
  // Clock rates and timing
  // ----------------------------------------------------------------
  localparam int unsigned PMC_CLK_HZ       = 100_000_000;
  localparam int unsigned PMC_XTAL_HZ      = 10_000_000;
  localparam int unsigned PMC_SLOW_HZ      = 32_000;
  localparam int unsigned PMC_XTAL_TICK    = PMC_CLK_HZ / PMC_XTAL_HZ;
  localparam int unsigned PMC_SLOW_HALF    = PMC_CLK_HZ / (2 * PMC_SLOW_HZ);
  localparam int unsigned PMC_XTAL_START_US = 50;
  localparam int unsigned PMC_XTAL_START_CYC =
    (PMC_XTAL_START_US * (PMC_CLK_HZ / 1_000_000));
  localparam int unsigned PMC_RECAL_S      = 30;
  localparam int unsigned PMC_RECAL_SLOW   = PMC_RECAL_S * PMC_SLOW_HZ;
  localparam int unsigned PMC_CAL_SLOW_CYC = 16;
  localparam logic [15:0] PMC_LONG_PERIOD  = 16'h8000;
  localparam int unsigned PMC_AFC_SETTLE   = 2;
  localparam int unsigned PMC_CNT_W        = 24;
  // ----------------------------------------------------------------
  // Reset values of the command bits
  // ----------------------------------------------------------------
  localparam logic        PMC_RST_RX_ON    = 1'b0;
  localparam logic        PMC_RST_XTAL_ON  = 1'b0;
  localparam logic        PMC_RST_WKUP_ON  = 1'b1;
  localparam logic        PMC_RST_BAT_ON   = 1'b0;
  localparam logic        PMC_RST_SLOW_SEL = 1'b1;
  localparam logic        PMC_RST_CAL_OFF  = 1'b0;
  localparam logic        PMC_RST_AFC_ON   = 1'b1;
  localparam logic [2:0]  PMC_RST_CLK_DIV  = 3'h0;
  localparam logic [15:0] PMC_RST_PERIOD   = 16'h0040;
  localparam int unsigned PMC_CAL_OFF_BIT  = 4;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PMC_ACTIVE  = 2'b00,
    PMC_IDLE    = 2'b01,
    PMC_SLEEP   = 2'b10,
    PMC_STANDBY = 2'b11
  } pmc_mode_t;

  typedef enum logic [1:0] {
    PMC_RD_IDLE   = 2'b00,
    PMC_RD_SETTLE = 2'b01,
    PMC_RD_TAKE   = 2'b10
  } pmc_rd_t;

  // Half period of the fast output in system cycles; code 0 gives 1 MHz
  function automatic logic [15:0] pmc_fast_half(input logic [2:0] div);
    logic [15:0] xdiv;
    xdiv = 16'h0;
    case (div)
      3'h0: xdiv = 16'h000a;
      3'h1: xdiv = 16'h0008;
      3'h2: xdiv = 16'h0006;
      3'h3: xdiv = 16'h0005;
      3'h4: xdiv = 16'h0004;
      3'h5: xdiv = 16'h0003;
      3'h6: xdiv = 16'h0002;
      default: xdiv = 16'h0001;
    endcase
    return 16'((32'(xdiv) * PMC_XTAL_TICK) / 2);
  endfunction
endpackage

// ---- pmc_if.sv ----
// Link between the receiver clock controller and its host microcontroller
`timescale 1ns/1ns
`default_nettype none
interface pmc_if;
  logic        rx_on;
  logic        crystal_oscillator_on;
  logic        wakeup_timer_on;
  logic        battery_detector_on;
  logic        clock_output_off;
  logic        slow_clk_sel;
  logic        cal_off;
  logic        afc_on;
  logic [2:0]  clk_div;
  logic [15:0] wakeup_period;
  logic        mcu_clk;
  logic        wakeup_evt;
  logic        cal_done;
  logic [6:0]  freq_offset;

  modport device (
    input  rx_on, crystal_oscillator_on, wakeup_timer_on,
    input  battery_detector_on, clock_output_off, slow_clk_sel,
    input  cal_off, afc_on, clk_div, wakeup_period,
    output mcu_clk, wakeup_evt, cal_done, freq_offset
  );
  modport host (
    output rx_on, crystal_oscillator_on, wakeup_timer_on,
    output battery_detector_on, clock_output_off, slow_clk_sel,
    output cal_off, afc_on, clk_div, wakeup_period,
    input  mcu_clk, wakeup_evt, cal_done, freq_offset
  );
endinterface
`default_nettype wire

// ---- pmc_host.sv ----
// Host end: holds the command bits and takes the output clock
`timescale 1ns/1ns
`default_nettype none
module pmc_host
  import pmc_pkg::*;
(
  input  wire logic        SYS_CLK_IN,
  input  wire logic        SYS_RST_IN,
  pmc_if.host              link,
  input  wire logic        WR_IN,
  input  wire logic        RX_ON_IN,
  input  wire logic        XTAL_ON_IN,
  input  wire logic        WKUP_ON_IN,
  input  wire logic        BAT_ON_IN,
  input  wire logic        SLOW_SEL_IN,
  input  wire logic        CAL_OFF_IN,
  input  wire logic        AFC_ON_IN,
  input  wire logic [2:0]  CLK_DIV_IN,
  input  wire logic [15:0] PERIOD_IN,
  input  wire logic        OFFSET_RD_IN,
  output logic             MCU_CLK_OUT,
  output logic [6:0]       OFFSET_OUT,
  output logic             OFFSET_VALID_OUT,
  output logic             WAKEUP_OUT
);
  // ----------------------------------------------------------------
  // Command bits
  // ----------------------------------------------------------------
  logic        rx_ff, xtal_ff, wkup_ff, bat_ff, slow_ff;
  logic        cal_off_ff, afc_user_ff;
  logic [2:0]  div_ff;
  logic [15:0] per_ff;
  // Clearing the timer bit would stall a pending switch to slow clock
  wire nxt_wkup = WKUP_ON_IN | SLOW_SEL_IN;
  // Calibration may only be switched off after one has completed
  wire nxt_cal_off = CAL_OFF_IN & link.cal_done;

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      rx_ff       <= PMC_RST_RX_ON;
      xtal_ff     <= PMC_RST_XTAL_ON;
      wkup_ff     <= PMC_RST_WKUP_ON;
      bat_ff      <= PMC_RST_BAT_ON;
      slow_ff     <= PMC_RST_SLOW_SEL;
      cal_off_ff  <= PMC_RST_CAL_OFF;
      afc_user_ff <= PMC_RST_AFC_ON;
      div_ff      <= PMC_RST_CLK_DIV;
      per_ff      <= PMC_RST_PERIOD;
    end else if (WR_IN) begin
      rx_ff       <= RX_ON_IN;
      xtal_ff     <= XTAL_ON_IN;
      wkup_ff     <= nxt_wkup;
      bat_ff      <= BAT_ON_IN;
      slow_ff     <= SLOW_SEL_IN;
      cal_off_ff  <= nxt_cal_off;
      afc_user_ff <= AFC_ON_IN;
      div_ff      <= CLK_DIV_IN;
      per_ff      <= PERIOD_IN;
    end
  end

  // ----------------------------------------------------------------
  // Offset read with AFC paused
  // ----------------------------------------------------------------
  pmc_rd_t    rd_ff;
  logic [1:0] wait_ff;
  logic [6:0] offs_ff;
  logic       offs_vld_ff;
  wire  afc_drv = afc_user_ff & (rd_ff == PMC_RD_IDLE);

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      rd_ff       <= PMC_RD_IDLE;
      wait_ff     <= '0;
      offs_ff     <= '0;
      offs_vld_ff <= 1'b0;
    end else begin
      offs_vld_ff <= 1'b0;
      case (rd_ff)
        PMC_RD_IDLE: begin
          wait_ff <= 2'(PMC_AFC_SETTLE);
          if (OFFSET_RD_IN) begin
            rd_ff <= PMC_RD_SETTLE;
          end
        end
        PMC_RD_SETTLE: begin
          wait_ff <= wait_ff - 2'h1;
          if (wait_ff == 2'h1) begin
            rd_ff <= PMC_RD_TAKE;
          end
        end
        PMC_RD_TAKE: begin
          offs_ff     <= link.freq_offset;
          offs_vld_ff <= 1'b1;
          rd_ff       <= PMC_RD_IDLE;
        end
        default: rd_ff <= PMC_RD_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Clock pin synchroniser and wake-up event
  // ----------------------------------------------------------------
  logic clk_s1_ff, clk_s2_ff, wk_ff;
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      clk_s1_ff <= 1'b0;
      clk_s2_ff <= 1'b0;
      wk_ff     <= 1'b0;
    end else begin
      clk_s1_ff <= link.mcu_clk;
      clk_s2_ff <= clk_s1_ff;
      wk_ff     <= link.wakeup_evt;
    end
  end

  assign link.rx_on                 = rx_ff;
  assign link.crystal_oscillator_on = xtal_ff;
  assign link.wakeup_timer_on       = wkup_ff;
  assign link.battery_detector_on   = bat_ff;
  assign link.clock_output_off      = 1'b0;
  assign link.slow_clk_sel          = slow_ff;
  assign link.cal_off               = cal_off_ff;
  assign link.afc_on                = afc_drv;
  assign link.clk_div               = div_ff;
  assign link.wakeup_period         = per_ff;
  assign MCU_CLK_OUT                = clk_s2_ff;
  assign OFFSET_OUT                 = offs_ff;
  assign OFFSET_VALID_OUT           = offs_vld_ff;
  assign WAKEUP_OUT                 = wk_ff;
endmodule
`default_nettype wire

// ---- pmc_assertions.sv ----
// Checker of the link between the host and device clock controller ends
`timescale 1ns/1ns
`default_nettype none
module pmc_assertions (
  input wire logic       SYS_CLK_IN,
  input wire logic       SYS_RST_IN,
  input wire logic       rx_on,
  input wire logic       crystal_oscillator_on,
  input wire logic       wakeup_timer_on,
  input wire logic       clock_output_off,
  input wire logic       slow_clk_sel,
  input wire logic       cal_off,
  input wire logic       afc_on,
  input wire logic       mcu_clk,
  input wire logic       wakeup_evt,
  input wire logic       cal_done,
  input wire logic [6:0] freq_offset
);
  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (SYS_RST_IN);

  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  // Offset read: AFC off for three cycles, then back on
  sequence s_afc_gap;
    !afc_on [*3] ##1 afc_on;
  endsequence
  sequence s_no_source;
    (!crystal_oscillator_on && !rx_on && !wakeup_timer_on) [*8];
  endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_dc_held_low: assert property (!clock_output_off)
    else $error("clock output disable set");
  a_high_min_width: assert property ($rose(mcu_clk) |-> mcu_clk [*5])
    else $error("high phase too short");
  a_low_min_width: assert property ($fell(mcu_clk) |-> !mcu_clk [*5])
    else $error("low phase too short");
  a_no_source_low: assert property (s_no_source |-> !mcu_clk)
    else $error("clock output runs with no source");
  a_slow_needs_timer: assert property (slow_clk_sel |-> wakeup_timer_on)
    else $error("slow clock selected without timer");
  a_wake_single: assert property (wakeup_evt |=> !wakeup_evt)
    else $error("wake event longer than one cycle");
  a_timer_off_quiet: assert property (
    (!wakeup_timer_on) [*3] |-> !wakeup_evt)
    else $error("wake event with timer off");
  a_cal_done_sticky: assert property (cal_done |=> cal_done)
    else $error("calibration done dropped");
  a_cal_off_gated: assert property ($rose(cal_off) |-> cal_done)
    else $error("calibration disabled before first one");
  a_afc_read_gap: assert property ($fell(afc_on) |-> s_afc_gap)
    else $error("AFC gap length wrong");
  a_offset_frozen: assert property (
    $changed(freq_offset) |-> !$past(afc_on))
    else $error("offset changed with AFC on");
endmodule
`default_nettype wire

// ---- power_mode_clock_output_ctrl_bench.sv ----
// Bench joining the host and device ends of the clock controller
`timescale 1ns/1ns
`default_nettype none
module power_mode_clock_output_ctrl_bench
  import pmc_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        wr, rd, rx, xt, wk, bt, sl, co;
  logic [2:0]  dv;
  logic [15:0] pr;
  logic [6:0]  afc_val, off;
  logic        offv, wake, mclk, xrdy, cal;
  logic [1:0]  mode;
  int          n_errors = 0;
  int          compares = 0;
  int          cyc = 0;
  // Full fast periods per divider code, in system cycles
  logic [15:0] fper [8] = '{16'h0064, 16'h0050, 16'h003c, 16'h0032,
                            16'h0028, 16'h001e, 16'h0014, 16'h000a};

  pmc_if link_if ();

  pmc_device #(.XTAL_START_CYC(20), .RECAL_SLOW_CYC(4)) pmc_device_i (
    .SYS_CLK_IN      (sys_clk),
    .SYS_RST_IN      (sys_rst),
    .link            (link_if),
    .AFC_OFFSET_IN   (afc_val),
    .MODE_OUT        (mode),
    .XTAL_READY_OUT  (xrdy),
    .CALIBRATING_OUT (cal)
  );
  pmc_host pmc_host_i (
    .SYS_CLK_IN       (sys_clk),
    .SYS_RST_IN       (sys_rst),
    .link             (link_if),
    .WR_IN            (wr),
    .RX_ON_IN         (rx),
    .XTAL_ON_IN       (xt),
    .WKUP_ON_IN       (wk),
    .BAT_ON_IN        (bt),
    .SLOW_SEL_IN      (sl),
    .CAL_OFF_IN       (co),
    .AFC_ON_IN        (1'b1),
    .CLK_DIV_IN       (dv),
    .PERIOD_IN        (pr),
    .OFFSET_RD_IN     (rd),
    .MCU_CLK_OUT      (mclk),
    .OFFSET_OUT       (off),
    .OFFSET_VALID_OUT (offv),
    .WAKEUP_OUT       (wake)
  );
  pmc_assertions pmc_assertions_i (
    .SYS_CLK_IN            (sys_clk),
    .SYS_RST_IN            (sys_rst),
    .rx_on                 (link_if.rx_on),
    .crystal_oscillator_on (link_if.crystal_oscillator_on),
    .wakeup_timer_on       (link_if.wakeup_timer_on),
    .clock_output_off      (link_if.clock_output_off),
    .slow_clk_sel          (link_if.slow_clk_sel),
    .cal_off               (link_if.cal_off),
    .afc_on                (link_if.afc_on),
    .mcu_clk               (link_if.mcu_clk),
    .wakeup_evt            (link_if.wakeup_evt),
    .cal_done              (link_if.cal_done),
    .freq_offset           (link_if.freq_offset)
  );

  always #5 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    if (n_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Inputs move 1 ns after the edge, outputs are read there too
  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr_cmd(input logic r, x, w, b, s, c,
                        input logic [2:0] d);
    {rx, xt, wk, bt, sl, co, dv} = {r, x, w, b, s, c, d};
    wr = 1'b1;
    step();
    wr = 1'b0;
    step();
    step();
  endtask
  task automatic mode_is(input logic [1:0] m);
    chk("mode", 16'(m), 16'(mode));
  endtask
  task automatic lvl(input logic v, inout int k);
    while (mclk !== v && k < 9000) begin
      step();
      k++;
    end
  endtask
  // First period after sync is dropped: it may hold the switch
  task automatic per(input logic [15:0] e);
    int k;
    k = 0;
    lvl(1'b0, k);
    lvl(1'b1, k);
    for (int j = 0; j < 2; j++) begin
      k = 0;
      lvl(1'b0, k);
      lvl(1'b1, k);
    end
    chk("period", e, 16'(k));
  endtask
  task automatic wake_gap();
    int k;
    k = 0;
    while (wake !== 1'b1 && k < 90000) begin
      step();
      k++;
    end
    k = 0;
    do begin
      step();
      k++;
    end while (wake !== 1'b1 && k < 9000);
    chk("wake gap", 16'h1868, 16'(k));
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 99000) begin
      n_errors++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int i;
    int n;
    {wr, rd, rx, xt, wk, bt, sl, co} = 8'h2a;
    dv = 3'h0;
    pr = 16'h0002;
    afc_val = 7'h35;
    repeat (3) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    step();
    mode_is(PMC_SLEEP);
    chk("dc", 16'h0000, 16'(link_if.clock_output_off));
    chk("cal_off", 16'h0000, 16'(link_if.cal_off));
    per(16'h0c34);
    wr_cmd(0, 0, 0, 0, 1, 1, 3'h0);
    chk("cal_off", 16'h0000, 16'(link_if.cal_off));
    chk("timer", 16'h0001, 16'(link_if.wakeup_timer_on));
    wr_cmd(0, 1, 1, 0, 1, 0, 3'h0);
    mode_is(PMC_IDLE);
    for (i = 0; i < 200 && xrdy !== 1'b1; i++) step();
    chk("ready", 16'h0001, 16'(xrdy));
    // Switch latency is at most one slow plus one fast period
    repeat (4000) step();
    for (i = 0; i < 8; i++) begin
      wr_cmd(0, 1, 1, 0, 1, 0, 3'(i));
      per(fper[i]);
    end
    wr_cmd(1, 1, 1, 0, 1, 0, 3'h0);
    mode_is(PMC_ACTIVE);
    // Second request cycle falls inside the running read
    rd = 1'b1;
    step();
    step();
    rd = 1'b0;
    n = 0;
    for (i = 0; i < 10; i++) begin
      if (offv === 1'b1) begin
        n++;
        chk("offset", 16'h0035, 16'(off));
      end
      step();
    end
    chk("reads", 16'h0001, 16'(n));
    // Offset must not follow the measurement while AFC runs
    afc_val = 7'h4b;
    repeat (3) step();
    chk("frozen", 16'h0035, 16'(link_if.freq_offset));
    wr_cmd(0, 0, 1, 0, 1, 0, 3'h0);
    mode_is(PMC_SLEEP);
    per(16'h0c34);
    wake_gap();
    chk("cal_done", 16'h0001, 16'(link_if.cal_done));
    wr_cmd(0, 0, 1, 0, 1, 1, 3'h0);
    chk("cal_off", 16'h0001, 16'(link_if.cal_off));
    wr_cmd(0, 0, 0, 0, 0, 1, 3'h0);
    mode_is(PMC_STANDBY);
    repeat (3200) step();
    n = 0;
    for (i = 0; i < 400; i++) begin
      step();
      if (mclk !== 1'b0) n++;
    end
    chk("clk low", 16'h0000, 16'(n));
    wr_cmd(0, 0, 0, 1, 0, 1, 3'h0);
    mode_is(PMC_SLEEP);
    pr = 16'h8000;
    wr_cmd(0, 0, 1, 0, 0, 1, 3'h0);
    chk("calibrating", 16'h0000, 16'(cal));
    // Long period with autocal back on: recal after four slow cycles
    wr_cmd(0, 0, 1, 0, 0, 0, 3'h0);
    for (i = 0; i < 13000 && cal !== 1'b1; i++) step();
    chk("recal", 16'h0001, 16'(cal));
    end_sim();
  end
endmodule
`default_nettype wire
